// >>> shared/ird_pkg.sv
/*
 Constants for the interrupt distributor register block: offsets, field
 positions, reset values and decode widths. Assumes a 12-bit byte address
 window and 32-bit register data.
*/
`default_nettype none
package ird_pkg;
   localparam int          ADDR_W          = 12;
   localparam int          DATA_W          = 32;
   localparam int          BANK_BITS       = 32;
   localparam int          CFG_PER_WORD    = 16;
   localparam int          FIRST_SPI       = 32;
   localparam int          LAST_SGI        = 15;
   // Offsets
   localparam logic [11:0] OFS_CONTROL     = 12'h000;
   localparam logic [11:0] OFS_TYPE        = 12'h004;
   localparam logic [11:0] OFS_IDENT       = 12'h008;
   localparam logic [11:0] OFS_SECURITY    = 12'h080;
   localparam logic [11:0] OFS_EN_SET      = 12'h100;
   localparam logic [11:0] OFS_EN_CLR      = 12'h180;
   localparam logic [11:0] OFS_PEND_SET    = 12'h200;
   localparam logic [11:0] OFS_PEND_CLR    = 12'h280;
   localparam logic [11:0] OFS_ACTIVE      = 12'h300;
   localparam logic [11:0] OFS_PRIORITY    = 12'h400;
   localparam logic [11:0] OFS_TARGET      = 12'h800;
   localparam logic [11:0] OFS_TRIG_CFG    = 12'hC00;
   localparam int          TARGET_BYTES    = 32;
   // Fields
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          TYPE_SEC_BIT    = 10;
   localparam int          TYPE_CPU_LSB    = 5;
   localparam int          TYPE_LINES_LSB  = 0;
   localparam int          ID_PRODUCT_LSB  = 24;
   localparam int          ID_VARIANT_LSB  = 16;
   localparam int          ID_REVISION_LSB = 12;
   localparam int          ID_CONT_LSB     = 8;
   localparam int          ID_CODE_LSB     = 0;
   // Values
   localparam logic        SEC_EXT_PRESENT = 1'b1;
   localparam logic [2:0]  CPU_COUNT_M1    = 3'h0;
   localparam logic [4:0]  LINES_FIELD     = 5'h2;
   localparam logic        CTRL_RESET      = 1'b0;
   localparam logic [7:0]  PRIO_RESET      = 8'h00;
   localparam logic [7:0]  TARGET_VALUE    = 8'h01;
   localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> rtl/ird_distributor.sv
/*
 Interrupt distributor register block: control, type and identification
 registers, per-interrupt security, enable, pending, active, trigger
 configuration and priority storage, and the forwarded pending vector.
 Assumes a single-cycle register port on clk and peripheral lines that are
 asynchronous to clk.
*/
// Notes on behaviour
// - Global enable off ignores lines, forwards nothing
// - Type register reports security extensions present
// - Type field holds CPU interfaces minus one
// - Type field N gives 32(N+1) interrupts
// - Identification holds product, variant, revision fields
// - Low twelve bits carry implementer code
// - Security bit per interrupt, zero is Secure
// - ID N at word N/32, bit N%32
// - Set-enable write one enables, zero ignored
// - Clear-enable write one disables, zero ignored
// - Set-pending read shows pending, resets zero
// - Set-pending write zero does nothing
// - Edge: write one adds pending state
// - Level not pending: write one adds pending; code ignores set-pending writes for IDs 0-31
// - Level pending: write latches pending state; code ignores set-pending writes for IDs 0-31
// - Priority and target bytes accept byte access
// - IDs 0-15 software, 32 up peripheral
`timescale 1ns/100ps
`default_nettype none
module ird_distributor #(
   parameter int           NUM_IRQ     = 32 * (int'(ird_pkg::LINES_FIELD) + 1),
   parameter logic [7:0]   PRODUCT_ID  = 8'h00,  // Arbitrary value
   parameter logic [3:0]   VARIANT     = 4'h0,   // Arbitrary value
   parameter logic [3:0]   REVISION    = 4'h0,   // Arbitrary value
   parameter logic [3:0]   IMPL_CONT   = 4'h0,   // Arbitrary value
   parameter logic [6:0]   IMPL_CODE   = 7'h00   // Arbitrary value
) (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   input  wire logic                      bus_req,
   input  wire logic                      bus_write,
   input  wire logic                      bus_byte,
   input  wire logic [11:0]               bus_addr,
   input  wire logic [31:0]               bus_wdata,
   output logic      [31:0]               bus_rdata,
   output logic                           bus_done,
   input  wire logic [NUM_IRQ-1:0]        irq_lines,
   input  wire logic                      cpu_ack,
   input  wire logic [$clog2(NUM_IRQ)-1:0] cpu_ack_id,
   input  wire logic                      cpu_eoi,
   input  wire logic [$clog2(NUM_IRQ)-1:0] cpu_eoi_id,
   output logic      [NUM_IRQ-1:0]        fwd_pending,
   output logic      [NUM_IRQ-1:0]        irq_nonsecure,
   output logic      [NUM_IRQ*8-1:0]      irq_priority
);
   localparam int NW = NUM_IRQ / ird_pkg::BANK_BITS;
   localparam int CW = NUM_IRQ / ird_pkg::CFG_PER_WORD;

   logic                ctrl_en;
   logic [NUM_IRQ-1:0]  line_s1;
   logic [NUM_IRQ-1:0]  line_s2;
   logic [NUM_IRQ-1:0]  line_s3;
   logic [NUM_IRQ-1:0]  en;
   logic [NUM_IRQ-1:0]  cfg_edge;
   logic [NUM_IRQ-1:0]  sw_pend;
   logic [NUM_IRQ-1:0]  edge_pend;
   logic [NUM_IRQ-1:0]  active;
   logic [NUM_IRQ-1:0]  pend;
   logic [CW*32-1:0]    cfg_rd;
   logic [7:0]          prio [NUM_IRQ];
   logic [31:0]         next_rdata;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic       wr_word;
   logic       wr_any;
   logic       in_sec;
   logic       in_ens;
   logic       in_enc;
   logic       in_pds;
   logic       in_pdc;
   logic       in_act;
   logic       in_cfg;
   logic       in_prio;
   logic       in_tgt;
   logic [4:0] bank_word;
   logic [5:0] cfg_word;

   assign wr_any    = bus_req & bus_write;
   assign wr_word   = wr_any & ~bus_byte;
   assign bank_word = bus_addr[6:2];
   assign cfg_word  = bus_addr[7:2];
   assign in_sec    = bus_addr[11:7] == ird_pkg::OFS_SECURITY[11:7];
   assign in_ens    = bus_addr[11:7] == ird_pkg::OFS_EN_SET[11:7];
   assign in_enc    = bus_addr[11:7] == ird_pkg::OFS_EN_CLR[11:7];
   assign in_pds    = bus_addr[11:7] == ird_pkg::OFS_PEND_SET[11:7];
   assign in_pdc    = bus_addr[11:7] == ird_pkg::OFS_PEND_CLR[11:7];
   assign in_act    = bus_addr[11:7] == ird_pkg::OFS_ACTIVE[11:7];
   assign in_cfg    = bus_addr[11:8] == ird_pkg::OFS_TRIG_CFG[11:8];
   assign in_prio   = bus_addr[11:10] == ird_pkg::OFS_PRIORITY[11:10];
   assign in_tgt    = bus_addr[11:5] == ird_pkg::OFS_TARGET[11:5];

   ////////////////////////////////////////////////////////////////////////
   // Global control and line synchronisers

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         ctrl_en <= ird_pkg::CTRL_RESET;
      else if (wr_word && bus_addr == ird_pkg::OFS_CONTROL)
         ctrl_en <= bus_wdata[ird_pkg::CTRL_EN_BIT];
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         line_s1 <= '0;
         line_s2 <= '0;
         line_s3 <= '0;
      end
      else
      begin
         line_s1 <= irq_lines;
         line_s2 <= line_s1;
         line_s3 <= line_s2;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-interrupt state

   genvar gi;
   generate
      for (gi = 0; gi < NUM_IRQ; gi++)
      begin : g_irq
         localparam logic [4:0] WI = 5'(gi / ird_pkg::BANK_BITS);
         localparam int         BI = gi % ird_pkg::BANK_BITS;
         localparam logic [5:0] CI = 6'(gi / ird_pkg::CFG_PER_WORD);
         localparam int         FI = gi % ird_pkg::CFG_PER_WORD;
         localparam bit         SPI = gi >= ird_pkg::FIRST_SPI;
         logic one_hit;
         logic edge_seen;
         logic level_now;
         logic acked;
         assign one_hit   = wr_word & (bank_word == WI) & bus_wdata[BI];
         // Lines count only while forwarding is on
         assign edge_seen = SPI & ctrl_en & cfg_edge[gi] & line_s2[gi] & ~line_s3[gi];
         assign level_now = SPI & ctrl_en & ~cfg_edge[gi] & line_s2[gi];
         assign acked     = cpu_ack & (cpu_ack_id == ($clog2(NUM_IRQ))'(gi));
         assign pend[gi]  = sw_pend[gi] | edge_pend[gi] | level_now;
         assign cfg_rd[2*gi]   = 1'b0;
         assign cfg_rd[2*gi+1] = cfg_edge[gi];

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               irq_nonsecure[gi] <= 1'b0;
            else if (wr_word && in_sec && bank_word == WI)
               irq_nonsecure[gi] <= bus_wdata[BI];
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               en[gi] <= 1'b0;
            else if (one_hit && in_ens)
               en[gi] <= 1'b1;
            else if (one_hit && in_enc)
               en[gi] <= 1'b0;
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               cfg_edge[gi] <= 1'b0;
            else if (SPI && wr_word && in_cfg && cfg_word == CI)
               cfg_edge[gi] <= bus_wdata[2*FI+1];
         end

         // Software latch: set beats clear and acknowledge
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               sw_pend[gi] <= 1'b0;
            else if (SPI && one_hit && in_pds)
               sw_pend[gi] <= 1'b1;
            else if ((one_hit && in_pdc) || acked)
               sw_pend[gi] <= 1'b0;
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               edge_pend[gi] <= 1'b0;
            else if (edge_seen)
               edge_pend[gi] <= 1'b1;
            else if ((one_hit && in_pdc) || acked)
               edge_pend[gi] <= 1'b0;
         end

         // Pending and active are separate, so a set keeps active intact
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               active[gi] <= 1'b0;
            else if (acked && pend[gi])
               active[gi] <= 1'b1;
            else if (cpu_eoi && cpu_eoi_id == ($clog2(NUM_IRQ))'(gi))
               active[gi] <= 1'b0;
         end

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               prio[gi] <= ird_pkg::PRIO_RESET;
            else if (wr_any && in_prio && bus_addr[9:2] == 8'(gi / 4)
                     && (!bus_byte || bus_addr[1:0] == 2'(gi % 4)))
               prio[gi] <= bus_wdata[8*(gi%4) +: 8];
         end

         assign irq_priority[8*gi +: 8] = prio[gi];

         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               fwd_pending[gi] <= 1'b0;
            else
               fwd_pending[gi] <= ctrl_en & en[gi] & pend[gi];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read path

   always_comb
   begin
      logic [9:0] pbase;
      pbase      = {bus_addr[9:2], 2'b00};
      next_rdata = ird_pkg::ZERO_WORD;
      if (in_prio || in_tgt)
      begin
         for (int l = 0; l < 4; l++)
         begin
            if (!bus_byte || bus_addr[1:0] == 2'(l))
            begin
               if (in_prio && int'(pbase) + l < NUM_IRQ)
                  next_rdata[8*l +: 8] = prio[int'(pbase) + l];
               if (in_tgt)
                  next_rdata[8*l +: 8] = ird_pkg::TARGET_VALUE;
            end
         end
      end
      else if (!bus_byte)
      begin
         if (bus_addr == ird_pkg::OFS_CONTROL)
            next_rdata[ird_pkg::CTRL_EN_BIT] = ctrl_en;
         else if (bus_addr == ird_pkg::OFS_TYPE)
         begin
            next_rdata[ird_pkg::TYPE_SEC_BIT]                = ird_pkg::SEC_EXT_PRESENT;
            next_rdata[ird_pkg::TYPE_CPU_LSB +: 3]           = ird_pkg::CPU_COUNT_M1;
            next_rdata[ird_pkg::TYPE_LINES_LSB +: 5]         = 5'(NW - 1);
         end
         else if (bus_addr == ird_pkg::OFS_IDENT)
         begin
            next_rdata[ird_pkg::ID_PRODUCT_LSB +: 8]         = PRODUCT_ID;
            next_rdata[ird_pkg::ID_VARIANT_LSB +: 4]         = VARIANT;
            next_rdata[ird_pkg::ID_REVISION_LSB +: 4]        = REVISION;
            next_rdata[ird_pkg::ID_CONT_LSB +: 4]            = IMPL_CONT;
            next_rdata[ird_pkg::ID_CODE_LSB +: 7]            = IMPL_CODE;
         end
         else if (int'(bank_word) < NW)
         begin
            if (in_sec)
               next_rdata = irq_nonsecure[32*bank_word +: 32];
            else if (in_ens || in_enc)
               next_rdata = en[32*bank_word +: 32];
            else if (in_pds || in_pdc)
               next_rdata = pend[32*bank_word +: 32];
            else if (in_act)
               next_rdata = active[32*bank_word +: 32];
         end
         if (in_cfg && int'(cfg_word) < CW)
            next_rdata = cfg_rd[32*cfg_word +: 32];
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         bus_rdata <= ird_pkg::ZERO_WORD;
      else if (bus_req && !bus_write)
         bus_rdata <= next_rdata;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         bus_done <= 1'b0;
      else
         bus_done <= bus_req;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_rd(logic [11:0] a);
      bus_req && !bus_write && !bus_byte && bus_addr == a;
   endsequence

   sequence s_wr_en0;
      bus_req && bus_write && !bus_byte && bus_addr == ird_pkg::OFS_EN_SET && bus_wdata[0];
   endsequence

   property p_off_quiet;
      !ctrl_en |=> fwd_pending == '0;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("forwarding while disabled");
   property p_type;
      s_rd(ird_pkg::OFS_TYPE) |=> bus_done && bus_rdata == 32'h0000_0402;
   endproperty
   a_type: assert property (p_type) else $error("type register value wrong");
   property p_set_en;
      s_wr_en0 |=> en[0];
   endproperty
   a_set_en: assert property (p_set_en) else $error("set enable not taken");
   property p_clr_en;
      bus_req && bus_write && !bus_byte && bus_addr == ird_pkg::OFS_EN_CLR && bus_wdata[0] |=> !en[0];
   endproperty
   a_clr_en: assert property (p_clr_en) else $error("clear enable not taken");
   property p_sec;
      bus_req && bus_write && !bus_byte && bus_addr == ird_pkg::OFS_SECURITY
      |=> irq_nonsecure[31:0] == $past(bus_wdata);
   endproperty
   a_sec: assert property (p_sec) else $error("security word not stored");

   property p_pend_set;
      bus_req && bus_write && !bus_byte && bus_addr == 12'h204 && bus_wdata[0] |=> pend[32];
   endproperty
   a_pend_set: assert property (p_pend_set) else $error("set pending lost");

   property p_sgi_no_pend;
      bus_req && bus_write && bus_addr == ird_pkg::OFS_PEND_SET |=> sw_pend[15:0] == '0;
   endproperty
   a_sgi_no_pend: assert property (p_sgi_no_pend) else $error("software id set pending");

   property p_unmapped;
      s_rd(12'h00C) |=> bus_rdata == ird_pkg::ZERO_WORD;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   property p_rd_after_wr;
      s_wr_en0 ##1 s_rd(ird_pkg::OFS_EN_SET) |=> bus_rdata[0];
   endproperty
   a_rd_after_wr: assert property (p_rd_after_wr) else $error("read missed prior write");

   property p_byte_prio;
      bus_req && bus_write && bus_byte && bus_addr == 12'h421
      ##1 bus_req && !bus_write && bus_byte && bus_addr == 12'h421
      |=> bus_rdata[15:8] == $past(bus_wdata[15:8], 2) && bus_rdata[7:0] == 8'h00;
   endproperty
   a_byte_prio: assert property (p_byte_prio) else $error("byte priority access wrong");

endmodule
`default_nettype wire

// >>> testbench/ird_cpu_model.sv
/*
 Processor-side model for the distributor: issues register accesses and
 acknowledge / end-of-interrupt pulses. Assumes the single-cycle request,
 one-cycle-later done port, driven at the falling edge of clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ird_cpu_model #(
   parameter int NUM_IRQ = 96
) (
   input  wire logic                       clk,
   input  wire logic                       bus_done,
   input  wire logic [31:0]                bus_rdata,
   output logic                            bus_req,
   output logic                            bus_write,
   output logic                            bus_byte,
   output logic      [11:0]                bus_addr,
   output logic      [31:0]                bus_wdata,
   output logic                            cpu_ack,
   output logic      [$clog2(NUM_IRQ)-1:0] cpu_ack_id,
   output logic                            cpu_eoi,
   output logic      [$clog2(NUM_IRQ)-1:0] cpu_eoi_id,
   output logic                            hung
);
   initial
   begin
      {bus_req, bus_write, bus_byte, bus_addr, bus_wdata} = '0;
      {cpu_ack, cpu_ack_id, cpu_eoi, cpu_eoi_id, hung} = '0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Byte accesses aimed by callers at priority space and at control / type words
   task automatic access(input logic w, input logic b, input logic [11:0] a,
                         input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(negedge clk);
      bus_req   = 1'b1;
      bus_write = w;
      bus_byte  = b;
      bus_addr  = a;
      bus_wdata = d;
      @(negedge clk);
      bus_req = 1'b0;
      // Released lines show inverse, not a stale copy
      bus_addr  = ~a;
      bus_wdata = ~d;
      while (bus_done !== 1'b1 && n < 4)
      begin
         @(negedge clk);
         n++;
      end
      hung = (bus_done !== 1'b1);
      r    = bus_rdata;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic pulse(input logic eoi, input logic [$clog2(NUM_IRQ)-1:0] id);
      @(negedge clk);
      cpu_ack    = ~eoi;
      cpu_eoi    = eoi;
      cpu_ack_id = id;
      cpu_eoi_id = id;
      @(negedge clk);
      {cpu_ack, cpu_eoi} = 2'b00;
      cpu_ack_id = ~id;
      cpu_eoi_id = ~id;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Write then read of one address on consecutive edges
   task automatic access_pair(input logic b, input logic [11:0] a, input logic [31:0] d,
                              output logic [31:0] r);
      @(negedge clk);
      bus_req   = 1'b1;
      bus_write = 1'b1;
      bus_byte  = b;
      bus_addr  = a;
      bus_wdata = d;
      @(negedge clk);
      bus_write = 1'b0;
      bus_wdata = ~d;
      @(negedge clk);
      bus_req  = 1'b0;
      bus_addr = ~a;
      hung     = (bus_done !== 1'b1);
      r        = bus_rdata;
   endtask
endmodule
`default_nettype wire

// >>> testbench/irq_distributor_regs_tb_top.sv
/*
 Self-checking bench for the distributor registers. Assumes default
 parameters (96 interrupts, identification values zero) and the processor
 model as the only bus master.
*/
`timescale 1ns/100ps
`default_nettype none
module irq_distributor_regs_tb_top;
   logic        clk;
   logic        reset_n;
   logic        bus_req;
   logic        bus_write;
   logic        bus_byte;
   logic [11:0] bus_addr;
   logic [31:0] bus_wdata;
   logic [31:0] bus_rdata;
   logic        bus_done;
   logic [95:0] irq_lines;
   logic        cpu_ack;
   logic [6:0]  cpu_ack_id;
   logic        cpu_eoi;
   logic [6:0]  cpu_eoi_id;
   logic [95:0] fwd_pending;
   logic [95:0] irq_nonsecure;
   logic [767:0] irq_priority;
   logic        hung;
   logic [31:0] rdv;
   int          fails;
   int          checks_done;

   ird_distributor DUT (.clk(clk), .reset_n(reset_n), .bus_req(bus_req), .bus_write(bus_write),
      .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .bus_done(bus_done), .irq_lines(irq_lines), .cpu_ack(cpu_ack), .cpu_ack_id(cpu_ack_id),
      .cpu_eoi(cpu_eoi), .cpu_eoi_id(cpu_eoi_id), .fwd_pending(fwd_pending),
      .irq_nonsecure(irq_nonsecure), .irq_priority(irq_priority));
   ird_cpu_model cpu (.clk(clk), .bus_done(bus_done), .bus_rdata(bus_rdata), .bus_req(bus_req),
      .bus_write(bus_write), .bus_byte(bus_byte), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .cpu_ack(cpu_ack), .cpu_ack_id(cpu_ack_id), .cpu_eoi(cpu_eoi), .cpu_eoi_id(cpu_eoi_id),
      .hung(hung));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, seen);
         fails++;
      end
   endtask
   // Bus hang cuts the run short
   task automatic acc(input logic w, input logic b, input logic [11:0] a, input logic [31:0] d);
      cpu.access(w, b, a, d, rdv);
      if (hung === 1'b1)
      begin
         fails++;
         final_report();
      end
   endtask
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      acc(1'b0, 1'b0, a, 32'h0000_0000);
      check(name, rdv, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic pair(input logic b, input logic [11:0] a, input logic [31:0] d);
      cpu.access_pair(b, a, d, rdv);
      if (hung === 1'b1)
      begin
         fails++;
         final_report();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset_and_ro();
      rdchk("control", 12'h000, 32'h0000_0000);
      rdchk("type", 12'h004, 32'h0000_0402);
      acc(1'b1, 1'b0, 12'h004, 32'hFFFF_FFFF);
      rdchk("type_ro", 12'h004, 32'h0000_0402);
      rdchk("ident", 12'h008, 32'h0000_0000);
      check("ident_b7", {31'h0, rdv[7]}, 32'h0000_0000);
      rdchk("security", 12'h080, 32'h0000_0000);
      rdchk("pending", 12'h208, 32'h0000_0000);
      rdchk("unmapped", 12'hF00, 32'h0000_0000);
      rdchk("unmapped_c", 12'h00C, 32'h0000_0000);
      acc(1'b0, 1'b1, 12'h004, 32'h0000_0000);
      check("type_byte", rdv, 32'h0000_0000);
      acc(1'b1, 1'b1, 12'h000, 32'h0000_0001);
      rdchk("ctrl_byte_wr", 12'h000, 32'h0000_0000);
   endtask
   task automatic sc_security();
      acc(1'b1, 1'b0, 12'h088, 32'h8000_0001);
      rdchk("sec_word2", 12'h088, 32'h8000_0001);
      rdchk("sec_word0", 12'h080, 32'h0000_0000);
      check("ns_ids", {29'h0, irq_nonsecure[95], irq_nonsecure[65], irq_nonsecure[64]},
            32'h0000_0005);
   endtask
   task automatic sc_enable();
      acc(1'b1, 1'b0, 12'h108, 32'h0000_00F0);
      acc(1'b1, 1'b0, 12'h108, 32'h0000_0000);
      rdchk("en_set", 12'h108, 32'h0000_00F0);
      acc(1'b1, 1'b0, 12'h188, 32'h0000_0010);
      acc(1'b1, 1'b0, 12'h188, 32'h0000_0000);
      rdchk("en_clr", 12'h188, 32'h0000_00E0);
      rdchk("en_set2", 12'h108, 32'h0000_00E0);
   endtask
   // Level id 33: global enable gate, then latch across line drop
   task automatic sc_level();
      acc(1'b1, 1'b0, 12'h104, 32'h0000_0002);
      irq_lines[33] = 1'b1;
      idle(4);
      rdchk("lvl_off", 12'h204, 32'h0000_0000);
      check("fwd_off", {31'h0, fwd_pending[33]}, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h000, 32'h0000_0001);
      idle(3);
      rdchk("lvl_on", 12'h204, 32'h0000_0002);
      check("fwd_on", {31'h0, fwd_pending[33]}, 32'h0000_0001);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0002);
      irq_lines[33] = 1'b0;
      idle(4);
      rdchk("lvl_latched", 12'h204, 32'h0000_0002);
      acc(1'b1, 1'b0, 12'h284, 32'h0000_0002);
      idle(3);
      rdchk("lvl_cleared", 12'h204, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0000);
      rdchk("wr_zero", 12'h204, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0002);
      rdchk("lvl_sw", 12'h204, 32'h0000_0002);
      acc(1'b1, 1'b0, 12'h284, 32'h0000_0002);
   endtask
   // Edge id 34 through pending, active, active-and-pending
   task automatic sc_edge();
      acc(1'b1, 1'b0, 12'hC08, 32'h0000_0020);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0004);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0004);
      rdchk("edge_pend", 12'h204, 32'h0000_0004);
      cpu.pulse(1'b0, 7'h22);
      idle(1);
      rdchk("edge_active", 12'h304, 32'h0000_0004);
      rdchk("edge_nopend", 12'h204, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h204, 32'h0000_0004);
      rdchk("edge_act_pend", 12'h204, 32'h0000_0004);
      rdchk("edge_act_kept", 12'h304, 32'h0000_0004);
      cpu.pulse(1'b1, 7'h22);
      idle(1);
      rdchk("edge_eoi", 12'h304, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h284, 32'h0000_0004);
      irq_lines[34] = 1'b1;
      idle(4);
      irq_lines[34] = 1'b0;
      idle(4);
      rdchk("edge_line", 12'h204, 32'h0000_0004);
      acc(1'b1, 1'b0, 12'h284, 32'h0000_0004);
      rdchk("edge_line_clr", 12'h204, 32'h0000_0000);
      acc(1'b1, 1'b0, 12'h200, 32'hFFFF_FFFF);
      rdchk("sgi_word", 12'h200, 32'h0000_0000);
   endtask
   task automatic sc_priority();
      acc(1'b1, 1'b1, 12'h421, 32'h0000_A500);
      check("prio33", {24'h0, irq_priority[8*33 +: 8]}, 32'h0000_00A5);
      rdchk("prio_word", 12'h420, 32'h0000_A500);
   endtask
   // Requests on consecutive edges, read right behind the write
   task automatic sc_back_to_back();
      pair(1'b0, 12'h100, 32'h0000_0001);
      check("rd_after_wr", rdv, 32'h0000_0001);
      pair(1'b1, 12'h421, 32'h0000_5A00);
      check("byte_prio_b2b", rdv, 32'h0000_5A00);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fails       = 0;
      checks_done = 0;
      reset_n     = 1'b0;
      irq_lines   = '0;
      idle(4);
      reset_n = 1'b1;
      sc_reset_and_ro();
      sc_security();
      sc_enable();
      sc_level();
      sc_edge();
      sc_priority();
      sc_back_to_back();
      final_report();
   end
endmodule
`default_nettype wire
